// ===== pllc_ctrl_bank.sv
// Purpose: Control register bank of a fractional-N synthesizer.
// Assumes: All inputs synchronous to clk_i; ticks are one-cycle pulses.
// Notes: Reached only over the four-wire serial port.
// Function
// [R1] Strobe bit 0 returns every configuration register to its default.
// [R2] Strobe bit 1 soft-resets the remaining digital logic.
// [R3] Strobe bit 3 clocks one temperature measurement; bit 2 unused.
// [R4] Bias enable low disables the whole synthesizer loop.
// [R5] Reference divider enable low holds the divider reset, like bypass.
// [R6] Square buffer needs sine-select low; sine buffer needs it high.
// [R7] Enable bit 9 picks the modulator clock: oscillator or reference.
// [R8] Bit 11 enables lock-detect logic and its output gates.
// [R9] Pump enable low leaves the pump output high impedance.
// [R10] Bit 13 low holds the fractional modulator in reset.
// [R11] Bit 14 low holds the lock detect circuit in reset.
// [R12] Bit 15 releases the cycle-slip guard flip-flops.
// [R13] Forced driver enable follows force value; else only during reads.
// [R14] Reference ratio divides the crystal input when enabled and selected.
// [R15] Divider select bit routes through divider when one, bypass when zero.
// [R16] Automatic selection bypasses the divider only when ratio is one.
// [R17] Reference bit 16 selects the sine-wave reference input.
// [R18] Duty mode bit stretches prescaler low time from 15 to 47.
// [R19] Enable bit 3 gates the crystal-muxed reference into the logic.
// [R20] Bits 4, 5, 6 deliver divided, square and sine clocks to logic.
// [R21] Bits 0 and 10 enable oscillator buffer and prescaler bias.
// [R22] Address zero reads a fixed identity code; writes act as strobes.
// [R23] Access is flag, six address bits, 24 data bits, MSB first.
// [R24] Strobes last one cycle; soft reset restores documented defaults.
`timescale 1ns/1ps
`default_nettype none
`include "pllc_defines.svh"
module pllc_ctrl_bank #(
  // Identity code returned at address zero; the value is arbitrary.
  parameter logic [23:0] CHIP_ID = 24'h0a5c3e
) (
  // Clock, reset and clock enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Serial port pins.
  input wire logic serial_clk_i,
  input wire logic serial_port_select_i,
  input wire logic serial_in_line_i,
  // Shared lock or serial output pin.
  output logic lock_or_serial_out_pin_o,
  output logic lock_or_serial_out_pin_oe_o,
  // Status and reference ticks from the loop.
  input wire logic lock_detect_i,
  input wire logic square_tick_i,
  input wire logic sine_tick_i,
  input wire logic osc_div_tick_i,
  // Controls to the loop blocks.
  output pllc_pkg::pllc_ctl_t ctl_o,
  // Clock ticks delivered to digital logic.
  output logic dig_ref_tick_o,
  output logic mod_clk_tick_o,
  // Soft reset and measurement strobes.
  output logic dig_soft_rst_o,
  output logic temp_measure_o
);

  // All state of the bank in one record.
  typedef struct packed {
    logic [15:0] enables;
    logic [1:0] drv_force;
    logic [16:0] ref_path;
    logic duty;
    logic reg_rst;
    logic dig_rst;
    logic temp;
    pllc_pkg::pllc_ctl_t ctl;
    logic pin_out;
    logic pin_oe;
    logic dig_tick;
    logic mod_tick;
  } pllc_bank_st_t;

  pllc_bank_st_t st_q;
  pllc_bank_st_t st_d;

  logic [5:0] rd_addr;
  logic [23:0] rd_data;
  pllc_pkg::pllc_wr_t wr;
  logic read_active;
  logic sdo;
  logic xref_tick;
  logic div_tick;
  logic div_rst;
  logic bias;

  // Address match shared by the read and write decoders.
  function automatic logic addr_is(input logic [5:0] a,
                                   input logic [5:0] b);
    addr_is = (a == b);
  endfunction : addr_is

  // Serial port slave.
  pllc_serial u_serial (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .serial_clk_i(serial_clk_i),
    .serial_port_select_i(serial_port_select_i),
    .serial_in_line_i(serial_in_line_i),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .wr_o(wr),
    .read_active_o(read_active),
    .sdo_o(sdo)
  );

  // Read decode; the strobe register reads as the identity code.
  always_comb begin
    if (addr_is(rd_addr, `PLLC_ADDR_STROBE)) begin
      rd_data = CHIP_ID; // R22
    end else if (addr_is(rd_addr, `PLLC_ADDR_ENABLE)) begin
      rd_data = {8'h00, st_q.enables};
    end else if (addr_is(rd_addr, `PLLC_ADDR_DRVFORCE)) begin
      rd_data = {22'h0, st_q.drv_force};
    end else if (addr_is(rd_addr, `PLLC_ADDR_REFPATH)) begin
      rd_data = {7'h00, st_q.ref_path};
    end else if (addr_is(rd_addr, `PLLC_ADDR_DUTY)) begin
      rd_data = {23'h0, st_q.duty};
    end else begin
      // Unmapped addresses read as zero.
      rd_data = 24'h000000;
    end
  end

  // The divider counter is cleared by the digital soft reset as well.
  assign div_rst = rst_i || st_q.dig_rst; // R2
  assign bias = st_q.enables[`PLLC_EN_BIAS];

  // Crystal mux ahead of the divider, gated into the digital logic.
  assign xref_tick = st_q.enables[`PLLC_EN_XREF_DIG] // R19
    && (st_q.ref_path[`PLLC_REF_SIN_SEL] ? sine_tick_i : square_tick_i);

  pllc_ref_div u_ref_div (
    .clk_i(clk_i),
    .rst_i(div_rst),
    .ce_i(ce_i),
    .enable_i(st_q.enables[`PLLC_EN_REFDIV] && bias),
    .select_i(st_q.ref_path[`PLLC_REF_SELECT]),
    .auto_i(st_q.ref_path[`PLLC_REF_AUTO]),
    .ratio_i(st_q.ref_path[`PLLC_REF_RATIO_MSB:0]),
    .ref_tick_i(xref_tick),
    .div_tick_o(div_tick)
  );

  // Register writes, strobes and derived controls.
  always_comb begin
    st_d = st_q;
    // Strobes act for exactly one cycle, then clear.
    st_d.reg_rst = 1'b0; // R24
    st_d.dig_rst = 1'b0; // R24
    st_d.temp = 1'b0; // R24

    if (st_q.reg_rst) begin
      // Register soft reset restores every field to its default.
      st_d.enables = `PLLC_RST_ENABLE; // R1
      st_d.drv_force = `PLLC_RST_DRVFORCE; // R1
      st_d.ref_path = `PLLC_RST_REFPATH; // R1
      st_d.duty = `PLLC_RST_DUTY; // R24
    end else if (wr.valid) begin
      if (addr_is(wr.addr, `PLLC_ADDR_STROBE)) begin
        st_d.reg_rst = wr.data[`PLLC_STB_SWRST_REGS]; // R1
        st_d.dig_rst = wr.data[`PLLC_STB_SWRST_DIG]; // R2
        st_d.temp = wr.data[`PLLC_STB_TEMP]; // R3
      end else if (addr_is(wr.addr, `PLLC_ADDR_ENABLE)) begin
        st_d.enables = wr.data[15:0];
      end else if (addr_is(wr.addr, `PLLC_ADDR_DRVFORCE)) begin
        st_d.drv_force = wr.data[1:0];
      end else if (addr_is(wr.addr, `PLLC_ADDR_REFPATH)) begin
        st_d.ref_path = wr.data[16:0];
      end else if (addr_is(wr.addr, `PLLC_ADDR_DUTY)) begin
        st_d.duty = wr.data[0];
      end
    end

    // Everything in the loop is held off while bias is low.
    st_d.ctl.loop_enable = bias; // R4
    st_d.ctl.osc_buf_on = bias && st_q.enables[`PLLC_EN_OSC_BUF]; // R21
    st_d.ctl.presc_bias_on = bias && st_q.enables[`PLLC_EN_PRESC]; // R21
    st_d.ctl.ref_div_run = bias && st_q.enables[`PLLC_EN_REFDIV]; // R5
    // A buffer only runs when the input select matches it.
    st_d.ctl.square_ref_buffer_on = bias
      && st_q.enables[`PLLC_EN_SQ_BUF]
      && !st_q.ref_path[`PLLC_REF_SIN_SEL]; // R6
    st_d.ctl.sine_ref_buffer_on = bias
      && st_q.enables[`PLLC_EN_SIN_BUF]
      && st_q.ref_path[`PLLC_REF_SIN_SEL]; // R6 R17
    st_d.ctl.mod_clk_from_osc = st_q.enables[`PLLC_EN_MODCLK_OSC]; // R7
    st_d.ctl.lock_gates_run = bias
      && st_q.enables[`PLLC_EN_LKD_GATES]; // R8
    st_d.ctl.pump_output_enable = bias
      && st_q.enables[`PLLC_EN_PUMP]; // R9
    st_d.ctl.mod_run = bias && st_q.enables[`PLLC_EN_MOD_RSTN]; // R10
    st_d.ctl.lock_run = bias && st_q.enables[`PLLC_EN_LOCK_RSTN]; // R11
    st_d.ctl.cycle_slip_guard = bias
      && st_q.enables[`PLLC_EN_CSG_RSTN]; // R12
    st_d.ctl.duty_long = st_q.duty; // R18
    st_d.ctl.presc_low_cycles = st_q.duty ? `PLLC_LOW_LONG
                                          : `PLLC_LOW_SHORT; // R18

    // Clocks delivered to the digital logic, each on its own enable.
    st_d.dig_tick = bias && (
      (st_q.enables[`PLLC_EN_DIVREF_DIG] && div_tick)
      || (st_q.enables[`PLLC_EN_SQR_DIG] && square_tick_i)
      || (st_q.enables[`PLLC_EN_SIN_DIG] && sine_tick_i)); // R20
    // Modulator clock source; it stops while the modulator is in reset.
    st_d.mod_tick = bias && st_q.enables[`PLLC_EN_MOD_RSTN]
      && (st_q.enables[`PLLC_EN_MODCLK_OSC] ? osc_div_tick_i
                                            : div_tick); // R7 R10

    // Shared pin: forced enable, otherwise driven only during reads.
    if (st_q.drv_force[`PLLC_DRV_FORCE_EN]) begin
      st_d.pin_oe = st_q.drv_force[`PLLC_DRV_FORCE_VAL]; // R13
    end else begin
      st_d.pin_oe = read_active; // R13
    end
    // Reads own the pin; between them it carries lock status.
    if (read_active) begin
      st_d.pin_out = sdo;
    end else begin
      st_d.pin_out = lock_detect_i && st_q.enables[`PLLC_EN_LKD_GATES]
        && st_q.enables[`PLLC_EN_LOCK_RSTN]; // R8 R11
    end
  end

  // Power-on reset loads the same defaults as the register soft reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.enables <= `PLLC_RST_ENABLE;
      st_q.drv_force <= `PLLC_RST_DRVFORCE;
      st_q.ref_path <= `PLLC_RST_REFPATH;
      st_q.duty <= `PLLC_RST_DUTY;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // Every output comes straight from a flip-flop.
  assign ctl_o = st_q.ctl;
  assign lock_or_serial_out_pin_o = st_q.pin_out;
  assign lock_or_serial_out_pin_oe_o = st_q.pin_oe;
  assign dig_ref_tick_o = st_q.dig_tick;
  assign mod_clk_tick_o = st_q.mod_tick;
  assign dig_soft_rst_o = st_q.dig_rst;
  assign temp_measure_o = st_q.temp;

endmodule : pllc_ctrl_bank
`default_nettype wire

// ===== pllc_ctrl_bank_properties.sv
// Purpose: Port-level checks of the control register bank.
// Assumes: Bound to pllc_ctrl_bank; latencies follow the hand-over.
// Notes: Relations only; values are checked by the bench.
`timescale 1ns/1ps
`default_nettype none
module pllc_ctrl_bank_properties (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched pins.
  input wire logic serial_port_select_i,
  input wire logic osc_div_tick_i,
  input wire pllc_pkg::pllc_ctl_t ctl_o,
  input wire logic dig_ref_tick_o,
  input wire logic mod_clk_tick_o,
  input wire logic dig_soft_rst_o,
  input wire logic temp_measure_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A strobe can only come from a frame, so a quiet port means no pulses.
  sequence s_idle; !serial_port_select_i [*6]; endsequence
  sequence s_bias_off; !ctl_o.loop_enable [*2]; endsequence
  property p_soft_pulse; dig_soft_rst_o |=> !dig_soft_rst_o; endproperty
  a_soft_pulse: assert property (p_soft_pulse)
    else $error("soft reset pulse too long");
  property p_temp_pulse; temp_measure_o |=> !temp_measure_o; endproperty
  a_temp_pulse: assert property (p_temp_pulse)
    else $error("measure pulse too long");
  property p_quiet; s_idle |-> !dig_soft_rst_o && !temp_measure_o; endproperty
  a_quiet: assert property (p_quiet)
    else $error("strobe without a frame");
  property p_duty;
    !$past(rst_i) |->
      ctl_o.presc_low_cycles == (ctl_o.duty_long ? 6'h2f : 6'h0f);
  endproperty
  a_duty: assert property (p_duty)
    else $error("prescaler low time wrong");
  property p_bias;
    !ctl_o.loop_enable |-> !(ctl_o.pump_output_enable || ctl_o.mod_run
      || ctl_o.lock_run || ctl_o.osc_buf_on);
  endproperty
  a_bias: assert property (p_bias)
    else $error("loop block on while bias off");
  property p_buffers;
    !(ctl_o.square_ref_buffer_on && ctl_o.sine_ref_buffer_on);
  endproperty
  a_buffers: assert property (p_buffers)
    else $error("both reference buffers on");
  property p_ticks_stop; s_bias_off |-> !dig_ref_tick_o && !mod_clk_tick_o;
  endproperty
  a_ticks_stop: assert property (p_ticks_stop)
    else $error("ticks while bias off");
  property p_mod_osc;
    ctl_o.mod_clk_from_osc && $past(ctl_o.mod_clk_from_osc) && mod_clk_tick_o
      |-> $past(osc_div_tick_i);
  endproperty
  a_mod_osc: assert property (p_mod_osc)
    else $error("modulator tick not from oscillator");
endmodule : pllc_ctrl_bank_properties
bind pllc_ctrl_bank pllc_ctrl_bank_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .serial_port_select_i(serial_port_select_i),
  .osc_div_tick_i(osc_div_tick_i), .ctl_o(ctl_o),
  .dig_ref_tick_o(dig_ref_tick_o), .mod_clk_tick_o(mod_clk_tick_o),
  .dig_soft_rst_o(dig_soft_rst_o), .temp_measure_o(temp_measure_o)
);
`default_nettype wire

// ===== pllc_defines.svh
// Purpose: Named offsets, field positions, reset values and counts.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Definitions only.
`ifndef PLLC_DEFINES_SVH
`define PLLC_DEFINES_SVH

// Register offsets on the six-bit serial address.
`define PLLC_ADDR_STROBE 6'h00
`define PLLC_ADDR_ENABLE 6'h01
`define PLLC_ADDR_DRVFORCE 6'h02
`define PLLC_ADDR_REFPATH 6'h03
`define PLLC_ADDR_DUTY 6'h04

// Strobe register bits.
`define PLLC_STB_SWRST_REGS 0
`define PLLC_STB_SWRST_DIG 1
`define PLLC_STB_TEMP 3

// Enable register bits.
`define PLLC_EN_OSC_BUF 0
`define PLLC_EN_BIAS 1
`define PLLC_EN_REFDIV 2
`define PLLC_EN_XREF_DIG 3
`define PLLC_EN_DIVREF_DIG 4
`define PLLC_EN_SQR_DIG 5
`define PLLC_EN_SIN_DIG 6
`define PLLC_EN_SQ_BUF 7
`define PLLC_EN_SIN_BUF 8
`define PLLC_EN_MODCLK_OSC 9
`define PLLC_EN_PRESC 10
`define PLLC_EN_LKD_GATES 11
`define PLLC_EN_PUMP 12
`define PLLC_EN_MOD_RSTN 13
`define PLLC_EN_LOCK_RSTN 14
`define PLLC_EN_CSG_RSTN 15

// Driver force register bits.
`define PLLC_DRV_FORCE_VAL 0
`define PLLC_DRV_FORCE_EN 1

// Reference path register fields.
`define PLLC_REF_RATIO_MSB 13
`define PLLC_REF_SELECT 14
`define PLLC_REF_AUTO 15
`define PLLC_REF_SIN_SEL 16

// Reset values.
`define PLLC_RST_ENABLE 16'hfe9b
`define PLLC_RST_DRVFORCE 2'h3
`define PLLC_RST_REFPATH 17'h08001
`define PLLC_RST_DUTY 1'h0
`define PLLC_RATIO_ONE 14'h0001

// Serial frame positions, counted in serial clock rising edges.
`define PLLC_EDGE_ADDR_DONE 6'h07
`define PLLC_EDGE_DATA_FIRST 6'h08
`define PLLC_EDGE_DATA_LAST 6'h1f
`define PLLC_EDGE_DONE 6'h20

// Prescaler output low time in oscillator cycles.
`define PLLC_LOW_SHORT 6'h0f
`define PLLC_LOW_LONG 6'h2f

`endif

// ===== pllc_host_model.sv
// Purpose: Host controller driving the four-wire serial port.
// Assumes: Called at 1 ns after a rising edge of clk_i.
// Notes: Serial clock rests low between frames.
`timescale 1ns/1ps
`default_nettype none
module pllc_host_model (
  // Clock.
  input wire logic clk_i,
  // Serial pins towards the device.
  output logic serial_clk_o,
  output logic select_o,
  output logic data_o,
  // Shared output pin level.
  input wire logic pin_i
);
  initial begin
    serial_clk_o = 1'b0;
    select_o = 1'b0;
    data_o = 1'b0;
  end
  // Step n edges, landing clear of the edge by the bench delay.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // Whole frame; each phase lasts two clocks so every edge is seen.
  task automatic xfer(input logic rd, input logic [5:0] addr,
                      input logic [23:0] wd, output logic [23:0] rdat);
    logic [30:0] bits;
    bits = {rd, addr, wd};
    rdat = 24'h0;
    select_o = 1'b1;
    for (int i = 0; i < 32; i++) begin
      if (i < 31) data_o = bits[30 - i];
      else data_o = ~data_o; // Nothing is held after the last bit.
      tick(2);
      if (i >= 8) rdat[31 - i] = pin_i;
      serial_clk_o = 1'b1;
      tick(2);
      serial_clk_o = 1'b0;
    end
    tick(2);
    select_o = 1'b0;
    data_o = ~data_o; // Released line shows no stale value.
    tick(2);
  endtask : xfer
endmodule : pllc_host_model
`default_nettype wire

// ===== pllc_pkg.sv
// Purpose: Types shared by the control register bank and its helpers.
// Assumes: Constants live in pllc_defines.svh.
// Notes: Nothing here is imported; users write pllc_pkg::name.
package pllc_pkg;

  // Decoded serial write handed from the port to the register bank.
  typedef struct packed {
    logic valid;
    logic [5:0] addr;
    logic [23:0] data;
  } pllc_wr_t;

  // Controls delivered to the analog and loop blocks.
  typedef struct packed {
    logic loop_enable;
    logic osc_buf_on;
    logic presc_bias_on;
    logic ref_div_run;
    logic square_ref_buffer_on;
    logic sine_ref_buffer_on;
    logic mod_clk_from_osc;
    logic lock_gates_run;
    logic pump_output_enable;
    logic mod_run;
    logic lock_run;
    logic cycle_slip_guard;
    logic duty_long;
    logic [5:0] presc_low_cycles;
  } pllc_ctl_t;

endpackage : pllc_pkg

// ===== pllc_ref_div.sv
// Purpose: Reference divider with bypass and automatic bypass choice.
// Assumes: Input ticks are one-cycle pulses synchronous to clk_i.
// Notes: A ratio field of zero wraps to the full 2^14 count.
`timescale 1ns/1ps
`default_nettype none
`include "pllc_defines.svh"
module pllc_ref_div (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Configuration.
  input wire logic enable_i,
  input wire logic select_i,
  input wire logic auto_i,
  input wire logic [13:0] ratio_i,
  // Reference ticks.
  input wire logic ref_tick_i,
  output logic div_tick_o
);

  typedef struct packed {
    logic [13:0] cnt;
    logic tick;
  } pllc_div_st_t;

  pllc_div_st_t st_q;
  pllc_div_st_t st_d;
  logic use_div;

  // Held in reset while disabled, which is the same as bypassing it.
  always_comb begin
    if (auto_i) begin
      use_div = enable_i && (ratio_i != `PLLC_RATIO_ONE); // R16
    end else begin
      use_div = enable_i && select_i; // R15
    end
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!enable_i) begin
      st_d.cnt = '0; // R5
      st_d.tick = ref_tick_i; // R5
    end else if (!use_div) begin
      st_d.cnt = '0;
      st_d.tick = ref_tick_i;
    end else if (ref_tick_i) begin
      // One output tick every ratio input ticks.
      if (st_q.cnt == ratio_i - `PLLC_RATIO_ONE) begin
        st_d.cnt = '0; // R14
        st_d.tick = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + `PLLC_RATIO_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign div_tick_o = st_q.tick;

endmodule : pllc_ref_div
`default_nettype wire

// ===== pllc_serial.sv
// Purpose: Four-wire serial port slave, oversampled by the system clock.
// Assumes: Serial pins are synchronous to clk_i; clock runs far faster.
// Notes: Read data is captured once the address is complete.
`timescale 1ns/1ps
`default_nettype none
`include "pllc_defines.svh"
module pllc_serial (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Serial pins.
  input wire logic serial_clk_i,
  input wire logic serial_port_select_i,
  input wire logic serial_in_line_i,
  // Register bank side.
  output logic [5:0] rd_addr_o,
  input wire logic [23:0] rd_data_i,
  output pllc_pkg::pllc_wr_t wr_o,
  output logic read_active_o,
  output logic sdo_o
);

  typedef struct packed {
    logic sclk;
    logic [5:0] edges;
    logic [30:0] shift_in;
    logic [23:0] shift_out;
    logic rd;
    logic sdo;
    pllc_pkg::pllc_wr_t wr;
  } pllc_ser_st_t;

  pllc_ser_st_t st_q;
  pllc_ser_st_t st_d;
  logic rise;

  // Frame: flag, six address bits, 24 data bits, MSB first.
  always_comb begin
    st_d = st_q;
    st_d.sclk = serial_clk_i;
    st_d.wr.valid = 1'b0;
    rise = serial_clk_i && !st_q.sclk;
    if (!serial_port_select_i) begin
      st_d.edges = '0;
      st_d.rd = 1'b0;
    end else if (rise && st_q.edges != `PLLC_EDGE_DONE) begin
      st_d.edges = st_q.edges + 6'h01;
      if (st_q.edges < `PLLC_EDGE_DATA_LAST) begin
        st_d.shift_in = {st_q.shift_in[29:0], serial_in_line_i}; // R23
      end
      if (st_q.edges == '0) begin
        st_d.rd = serial_in_line_i;
      end
      if (st_q.edges + 6'h01 == `PLLC_EDGE_ADDR_DONE) begin
        st_d.shift_out = rd_data_i;
      end
      if (st_q.rd && st_q.edges + 6'h01 >= `PLLC_EDGE_DATA_FIRST
          && st_q.edges + 6'h01 <= `PLLC_EDGE_DATA_LAST) begin
        st_d.sdo = st_q.shift_out[23]; // R23
        st_d.shift_out = {st_q.shift_out[22:0], 1'b0};
      end
      if (!st_q.rd && st_q.edges + 6'h01 == `PLLC_EDGE_DONE) begin
        st_d.wr.valid = 1'b1;
        st_d.wr.addr = st_q.shift_in[29:24];
        st_d.wr.data = st_q.shift_in[23:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // The address is complete and stable when the data is captured.
  assign rd_addr_o = {st_q.shift_in[4:0], serial_in_line_i};
  assign wr_o = st_q.wr;
  assign read_active_o = st_q.rd;
  assign sdo_o = st_q.sdo;

endmodule : pllc_serial
`default_nettype wire

// ===== tb_pllc_ctrl_bank.sv
// Purpose: Self-checking bench for the control register bank.
// Assumes: Host model gives whole frames; seed fixed at 51.
// Notes: Divider ratios are checked by counting ticks from a quiet start.
`timescale 1ns/1ps
`default_nettype none
module tb_pllc_ctrl_bank;
  // Identity code; the value is arbitrary.
  localparam logic [23:0] ID = 24'h3c1d5a;
  localparam logic [23:0] DFLT [6] = '{ID, 24'h00fe9b, 24'h000003,
    24'h008001, 24'h000000, 24'h000000};
  logic clk_i, rst_i, ce_i, sclk, sel, serial_in_line, pin, pin_oe, lock_det;
  logic sq_tick, sin_tick, osc_tick, ref_tick, mod_tick, soft_rst, temp;
  logic oe_seen, dy, quiet;
  logic [3:0] r4;
  logic [23:0] rd;
  logic [15:0] en;
  logic [16:0] rp;
  pllc_pkg::pllc_ctl_t ctl;
  integer seed = 51;
  int error_cnt = 0;
  int samples_checked = 0;
  int soft_n, temp_n, sq_n, osc_n, ref_n, mod_n;
  pllc_ctrl_bank #(.CHIP_ID(ID)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .serial_clk_i(sclk), .serial_port_select_i(sel),
    .serial_in_line_i(serial_in_line), .lock_or_serial_out_pin_o(pin),
    .lock_or_serial_out_pin_oe_o(pin_oe), .lock_detect_i(lock_det),
    .square_tick_i(sq_tick), .sine_tick_i(sin_tick),
    .osc_div_tick_i(osc_tick), .ctl_o(ctl), .dig_ref_tick_o(ref_tick),
    .mod_clk_tick_o(mod_tick), .dig_soft_rst_o(soft_rst),
    .temp_measure_o(temp));
  pllc_host_model u_host (.clk_i(clk_i), .serial_clk_o(sclk),
    .select_o(sel), .data_o(serial_in_line), .pin_i(pin_oe ? pin : ~pin));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Random ticks and lock status; ticks never stay high two cycles.
  initial begin
    {sq_tick, sin_tick, osc_tick, lock_det} = 4'h0;
    forever begin
      @(posedge clk_i);
      #1;
      r4 = 4'($random(seed));
      sq_tick = r4[0] & ~sq_tick & ~quiet;
      sin_tick = r4[1] & ~sin_tick & ~quiet;
      osc_tick = r4[2] & ~osc_tick & ~quiet;
      lock_det = r4[3];
    end
  end
  // Pulse counters and driver activity seen by the bench.
  always @(posedge clk_i) begin
    if (soft_rst === 1'b1) soft_n++;
    if (temp === 1'b1) temp_n++;
    if (sq_tick === 1'b1) sq_n++;
    if (osc_tick === 1'b1) osc_n++;
    if (ref_tick === 1'b1) ref_n++;
    if (mod_tick === 1'b1) mod_n++;
    if (pin_oe === 1'b1) oe_seen = 1'b1;
  end
  task automatic chk(input string what, input logic [23:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] unused;
    u_host.xfer(1'b0, a, d, unused);
  endtask : wr
  task automatic rdchk(input string what, input logic [5:0] a,
                       input logic [23:0] exp);
    logic [23:0] got;
    u_host.xfer(1'b1, a, 24'h0, got);
    chk(what, exp, got);
  endtask : rdchk
  // Expected controls from register contents.
  task automatic ctl_chk(input logic [15:0] e, input logic [16:0] r,
                         input logic d);
    pllc_pkg::pllc_ctl_t x, g;
    x = '0;
    g = ctl;
    x.mod_clk_from_osc = e[9];
    x.duty_long = d;
    x.presc_low_cycles = d ? 6'h2f : 6'h0f;
    if (e[1]) begin
      x.loop_enable = 1'b1;
      x.osc_buf_on = e[0];
      x.presc_bias_on = e[10];
      x.ref_div_run = e[2];
      x.square_ref_buffer_on = e[7] & ~r[16];
      x.sine_ref_buffer_on = e[8] & r[16];
      x.lock_gates_run = e[11];
      x.pump_output_enable = e[12];
      x.mod_run = e[13];
      x.lock_run = e[14];
      x.cycle_slip_guard = e[15];
    end
    chk("controls", {5'h0, x}, {5'h0, g});
  endtask : ctl_chk
  // Ticks stop while the divider is cleared, so counts start from zero.
  task automatic div_chk(input logic [15:0] e, input logic [16:0] r,
                         input int dv, input bit osc);
    wr(6'h01, {8'h0, e});
    wr(6'h03, {7'h0, r});
    quiet = 1'b1;
    wr(6'h00, 24'h2);
    {sq_n, osc_n, ref_n, mod_n} = '0;
    quiet = 1'b0;
    u_host.tick(300);
    quiet = 1'b1;
    u_host.tick(6);
    chk("divided ticks", 24'(sq_n / dv), 24'(ref_n));
    chk("modulator ticks", 24'(osc ? osc_n : sq_n / dv), 24'(mod_n));
  endtask : div_chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // A hang costs far more than the roughly 105 us that the tests need.
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    quiet = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    u_host.tick(2);
    ctl_chk(16'hfe9b, 17'h08001, 1'b0);
    wr(6'h05, 24'h5a5a5a);
    for (int a = 0; a < 6; a++) rdchk("readback", 6'(a), DFLT[a]);
    // Random settings, first with bias off; software keeps select legal.
    for (int i = 0; i < 6; i++) begin
      en = 16'($random(seed));
      rp = 17'($random(seed));
      dy = 1'($random(seed));
      if (i == 0) en[1] = 1'b0;
      en[8] = rp[16];
      if (rp[16]) en[7] = 1'b0;
      if (rp[13:0] < 14'h0002) rp[13:0] = 14'h0002;
      wr(6'h01, {8'h0, en});
      wr(6'h03, {7'h0, rp});
      wr(6'h04, {23'h0, dy});
      rdchk("enables", 6'h01, {8'h0, en});
      rdchk("refpath", 6'h03, {7'h0, rp});
      rdchk("duty", 6'h04, {23'h0, dy});
      ctl_chk(en, rp, dy);
    end
    // Divider ratio, selection, bypass and modulator clock source.
    div_chk(16'h221e, 17'h04003, 3, 1'b1);
    div_chk(16'h201e, 17'h08005, 5, 1'b0);
    div_chk(16'h201e, 17'h08001, 1, 1'b0);
    div_chk(16'h221a, 17'h04003, 1, 1'b1);
    // One strobe bit at a time; only its own pulse may show.
    for (int b = 1; b < 4; b++) begin
      soft_n = 0;
      temp_n = 0;
      wr(6'h00, 24'(1 << b));
      chk("soft pulses", 24'(b == 1), 24'(soft_n));
      chk("temp pulses", 24'(b == 3), 24'(temp_n));
    end
    wr(6'h02, 24'h0);
    chk("oe idle", 24'h0, {23'h0, pin_oe});
    oe_seen = 1'b0;
    rdchk("drive", 6'h02, 24'h0);
    chk("oe in read", 24'h1, {23'h0, oe_seen});
    wr(6'h02, 24'h2);
    oe_seen = 1'b0;
    u_host.xfer(1'b1, 6'h01, 24'h0, rd);
    chk("oe forced off", 24'h0, {23'h0, oe_seen});
    wr(6'h00, 24'h1);
    chk("oe forced on", 24'h1, {23'h0, pin_oe});
    rdchk("enables", 6'h01, 24'h00fe9b);
    rdchk("drvforce", 6'h02, 24'h000003);
    rdchk("refpath", 6'h03, 24'h008001);
    ctl_chk(16'hfe9b, 17'h08001, 1'b0);
    // Between reads the pin carries lock status, one cycle late.
    repeat (8) begin
      @(posedge clk_i);
      dy = lock_det;
      #1;
      chk("lock pin", {23'h0, dy}, {23'h0, pin});
    end
    // A frozen bank ignores a frame; a mid-run reset restores defaults.
    quiet = 1'b1;
    u_host.tick(4);
    ce_i = 1'b0;
    wr(6'h04, 24'h1);
    ce_i = 1'b1;
    rdchk("frozen duty", 6'h04, 24'h0);
    wr(6'h04, 24'h1);
    rst_i = 1'b1;
    u_host.tick(2);
    rst_i = 1'b0;
    rdchk("duty after reset", 6'h04, 24'h0);
    wrap_up();
  end
endmodule : tb_pllc_ctrl_bank
`default_nettype wire
